// ==== rtl/tc2_pkg.sv ====
// Constants and types for the timer waveform mode control block
package tc2_pkg;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hb4;
  localparam logic [7:0] ADDR_COUNTER = 8'hb8;
  localparam logic [7:0] ADDR_CMP_A = 8'hbc;
  localparam logic [7:0] ADDR_CMP_B = 8'hc0;
  localparam logic [7:0] ADDR_PIN_CFG = 8'hc4;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hcc;
  // Field positions
  localparam int CHAN_A_MODE_LSB = 6;
  localparam int CHAN_B_MODE_LSB = 4;
  localparam int WAVE_LOW_LSB = 0;
  localparam int CTRL_B_RUN_BIT = 0;
  localparam int CTRL_B_WAVE_HIGH_BIT = 3;
  localparam int PIN_DIR_LSB = 0;
  localparam int PIN_DATA_LSB = 4;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_MATCH_A_BIT = 1;
  localparam int IRQ_MATCH_B_BIT = 2;
  // Implemented bits per register
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h09;
  localparam logic [7:0] PIN_CFG_MASK = 8'h33;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // Waveform mode codes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_MAX = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;
  // Output mode codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  // Counter landmarks
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // Timer clock divider, system clocks per timer tick
  localparam int TICK_DIV_DEFAULT = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CLS_NORMAL,
    CLS_CTC,
    CLS_FAST,
    CLS_PHASE
  } tc2_class_t;
endpackage

// ==== rtl/tc2_chan_if.sv ====
// Signals between the timer core and one waveform channel
`timescale 1ns/1ps
interface tc2_chan_if;
  logic match;
  logic top_hit;
  logic cmp_at_top;
  logic down;
  tc2_pkg::tc2_class_t cls;
  logic wave_high;
  logic [1:0] out_mode;
  logic port_dir;
  logic port_data;
  logic wave;
  logic pin_out;
  logic pin_oe;
  modport core (
    output match, top_hit, cmp_at_top, down, cls, wave_high, out_mode,
    output port_dir, port_data,
    input wave, pin_out, pin_oe
  );
  modport chan (
    input match, top_hit, cmp_at_top, down, cls, wave_high, out_mode,
    input port_dir, port_data,
    output wave, pin_out, pin_oe
  );
endinterface

// ==== rtl/tc2_wave_chan.sv ====
// One compare output channel: waveform register and pin multiplexing
`timescale 1ns/1ps
module tc2_wave_chan #(
  parameter bit TOGGLE_IN_PWM = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  tc2_chan_if.chan ch
);
  logic pwm;
  logic hi;
  logic pwm_toggle;
  logic connected;
  logic next_wave;

  assign pwm = (ch.cls == tc2_pkg::CLS_FAST) || (ch.cls == tc2_pkg::CLS_PHASE);
  assign hi = ch.out_mode[1];
  // Toggle in PWM only where the channel supports it and bit 2 is set
  assign pwm_toggle = TOGGLE_IN_PWM && ch.wave_high &&
                      (ch.out_mode == tc2_pkg::OM_TOGGLE);
  // Nonzero code takes the pin, except PWM code 1 without toggle
  assign connected = (ch.out_mode != tc2_pkg::OM_OFF) &&
                     !(pwm && !hi && !pwm_toggle);

  always_comb begin
    next_wave = ch.wave;
    case (ch.cls)
      tc2_pkg::CLS_FAST: begin
        if (ch.top_hit && hi) begin
          next_wave = !ch.out_mode[0];
        end else if (ch.match && hi && !ch.cmp_at_top) begin
          next_wave = ch.out_mode[0];
        end else if (ch.match && pwm_toggle) begin
          next_wave = !ch.wave;
        end
      end
      tc2_pkg::CLS_PHASE: begin
        if (ch.match && hi) begin
          // At top with compare at top, act as the up-counting match
          if (ch.down && !ch.cmp_at_top) begin
            next_wave = !ch.out_mode[0];
          end else begin
            next_wave = ch.out_mode[0];
          end
        end else if (ch.match && pwm_toggle) begin
          next_wave = !ch.wave;
        end
      end
      default: begin
        if (ch.match) begin
          case (ch.out_mode)
            tc2_pkg::OM_TOGGLE: next_wave = !ch.wave;
            tc2_pkg::OM_CLEAR: next_wave = 1'b0;
            tc2_pkg::OM_SET: next_wave = 1'b1;
            default: next_wave = ch.wave;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch.wave <= 1'b0;
    end else begin
      ch.wave <= next_wave;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch.pin_out <= 1'b0;
      ch.pin_oe <= 1'b0;
    end else begin
      ch.pin_out <= connected ? next_wave : ch.port_data;
      ch.pin_oe <= ch.port_dir;
    end
  end
endmodule

// ==== rtl/tc2_timer_top.sv ====
// Timer waveform mode control with AXI4-Lite registers and two outputs
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module tc2_timer_top #(
  parameter int TICK_DIV = tc2_pkg::TICK_DIV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [tc2_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tc2_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_out_a_pin,
  output logic compare_out_a_oe,
  output logic compare_out_b_pin,
  output logic compare_out_b_oe,
  output logic irq
);
  localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  logic rst_q1;
  logic rst_n;
  // Bus state
  logic aw_held;
  logic w_held;
  logic [tc2_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic write_go;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cnt;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_pin;
  logic wr_status;
  logic wr_mask;
  logic wr_hit;
  logic [7:0] rd_val;
  logic rd_hit;
  // Registers
  logic [7:0] timer2_waveform_control;
  logic [7:0] ctrl_b;
  logic [7:0] counter_value;
  logic [7:0] cmp_a_buf;
  logic [7:0] cmp_b_buf;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] pin_cfg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  // Timer core
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic down;
  logic [2:0] wave_mode_field;
  tc2_pkg::tc2_class_t cls;
  logic [7:0] top;
  logic top_hit;
  logic ovf_evt;
  logic buf_load;
  logic [1:0] match_w;
  logic [1:0] pin_out_w;
  logic [1:0] pin_oe_w;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Write address and data may arrive in either order
  assign write_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (write_go) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (write_go) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    wr_cnt = 1'b0;
    wr_cmp_a = 1'b0;
    wr_cmp_b = 1'b0;
    wr_pin = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_hit = 1'b1;
    if (awaddr_q[7:2] == tc2_pkg::ADDR_CTRL_A[7:2]) begin
      wr_ctrl_a = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_CTRL_B[7:2]) begin
      wr_ctrl_b = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_COUNTER[7:2]) begin
      wr_cnt = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_CMP_A[7:2]) begin
      wr_cmp_a = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_CMP_B[7:2]) begin
      wr_cmp_b = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_PIN_CFG[7:2]) begin
      wr_pin = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_IRQ_STATUS[7:2]) begin
      wr_status = write_go && wstrb0_q;
    end else if (awaddr_q[7:2] == tc2_pkg::ADDR_IRQ_MASK[7:2]) begin
      wr_mask = write_go && wstrb0_q;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tc2_pkg::RESP_OKAY;
    end else if (write_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? tc2_pkg::RESP_OKAY : tc2_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr[7:2] == tc2_pkg::ADDR_CTRL_A[7:2]) begin
      rd_val = timer2_waveform_control & tc2_pkg::CTRL_A_MASK;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_CTRL_B[7:2]) begin
      rd_val = ctrl_b;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_COUNTER[7:2]) begin
      rd_val = counter_value;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_CMP_A[7:2]) begin
      rd_val = cmp_a_buf;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_CMP_B[7:2]) begin
      rd_val = cmp_b_buf;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_PIN_CFG[7:2]) begin
      rd_val = pin_cfg;
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_IRQ_STATUS[7:2]) begin
      rd_val = {5'h00, irq_status};
    end else if (s_axi_araddr[7:2] == tc2_pkg::ADDR_IRQ_MASK[7:2]) begin
      rd_val = {5'h00, irq_mask};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tc2_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_hit ? tc2_pkg::RESP_OKAY : tc2_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer2_waveform_control <= tc2_pkg::CTRL_RST;
      ctrl_b <= tc2_pkg::CTRL_RST;
      pin_cfg <= tc2_pkg::PIN_CFG_RST;
      irq_mask <= tc2_pkg::IRQ_RST;
      cmp_a_buf <= tc2_pkg::CMP_RST;
      cmp_b_buf <= tc2_pkg::CMP_RST;
    end else begin
      if (wr_ctrl_a) begin
        timer2_waveform_control <= wdata_q & tc2_pkg::CTRL_A_MASK;
      end
      if (wr_ctrl_b) begin
        ctrl_b <= wdata_q & tc2_pkg::CTRL_B_MASK;
      end
      if (wr_pin) begin
        pin_cfg <= wdata_q & tc2_pkg::PIN_CFG_MASK;
      end
      if (wr_mask) begin
        irq_mask <= wdata_q[2:0];
      end
      if (wr_cmp_a) begin
        cmp_a_buf <= wdata_q;
      end
      if (wr_cmp_b) begin
        cmp_b_buf <= wdata_q;
      end
    end
  end

  // Mode decode; reserved codes 4 and 6 fall back to plain counting
  assign wave_mode_field = {ctrl_b[tc2_pkg::CTRL_B_WAVE_HIGH_BIT],
    timer2_waveform_control[tc2_pkg::WAVE_LOW_LSB +: 2]};

  always_comb begin
    case (wave_mode_field)
      tc2_pkg::WM_CTC: cls = tc2_pkg::CLS_CTC;
      tc2_pkg::WM_FAST_MAX, tc2_pkg::WM_FAST_CMP: cls = tc2_pkg::CLS_FAST;
      tc2_pkg::WM_PHASE_MAX, tc2_pkg::WM_PHASE_CMP: cls = tc2_pkg::CLS_PHASE;
      default: cls = tc2_pkg::CLS_NORMAL;
    endcase
  end

  assign top = (wave_mode_field == tc2_pkg::WM_CTC ||
                wave_mode_field == tc2_pkg::WM_PHASE_CMP ||
                wave_mode_field == tc2_pkg::WM_FAST_CMP) ?
               compare_value_a : tc2_pkg::CNT_MAX;
  // Top reached on the way up; in fast PWM this is the wrap to bottom
  assign top_hit = tick && (counter_value == top) && !down;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (!ctrl_b[tc2_pkg::CTRL_B_RUN_BIT]) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
      tick <= (div_cnt == DIV_LAST);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= tc2_pkg::COUNTER_RST;
      down <= 1'b0;
    end else if (wr_cnt) begin
      counter_value <= wdata_q;
    end else if (cls != tc2_pkg::CLS_PHASE) begin
      down <= 1'b0;
      if (tick) begin
        if (cls != tc2_pkg::CLS_NORMAL && counter_value == top) begin
          counter_value <= tc2_pkg::CNT_BOTTOM;
        end else begin
          counter_value <= counter_value + 8'h01;
        end
      end
    end else if (tick) begin
      if (!down && counter_value >= top) begin
        down <= (top != tc2_pkg::CNT_BOTTOM);
        counter_value <= (top != tc2_pkg::CNT_BOTTOM) ?
                         counter_value - 8'h01 : tc2_pkg::CNT_BOTTOM;
      end else if (down && counter_value == tc2_pkg::CNT_BOTTOM) begin
        down <= 1'b0;
        counter_value <= counter_value + 8'h01;
      end else if (down) begin
        counter_value <= counter_value - 8'h01;
      end else begin
        counter_value <= counter_value + 8'h01;
      end
    end
  end

  assign buf_load = (cls == tc2_pkg::CLS_NORMAL) ||
                    (cls == tc2_pkg::CLS_CTC) || top_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_a <= tc2_pkg::CMP_RST;
      compare_value_b <= tc2_pkg::CMP_RST;
    end else if (buf_load) begin
      compare_value_a <= cmp_a_buf;
      compare_value_b <= cmp_b_buf;
    end
  end

  always_comb begin
    case (wave_mode_field)
      tc2_pkg::WM_PHASE_MAX, tc2_pkg::WM_PHASE_CMP:
        ovf_evt = tick && counter_value == tc2_pkg::CNT_BOTTOM;
      tc2_pkg::WM_FAST_CMP:
        ovf_evt = top_hit;
      default:
        ovf_evt = tick && counter_value == tc2_pkg::CNT_MAX;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      tc2_chan_if chif ();
      logic [7:0] cmp_g;
      assign cmp_g = (g == 0) ? compare_value_a : compare_value_b;
      assign chif.match = tick && (counter_value == cmp_g);
      assign chif.top_hit = top_hit;
      assign chif.cmp_at_top = (cmp_g == top);
      assign chif.down = down;
      assign chif.cls = cls;
      assign chif.wave_high = wave_mode_field[2];
      assign chif.out_mode = timer2_waveform_control[
        ((g == 0) ? tc2_pkg::CHAN_A_MODE_LSB : tc2_pkg::CHAN_B_MODE_LSB) +: 2];
      assign chif.port_dir = pin_cfg[tc2_pkg::PIN_DIR_LSB + g];
      assign chif.port_data = pin_cfg[tc2_pkg::PIN_DATA_LSB + g];
      assign match_w[g] = chif.match;
      assign pin_out_w[g] = chif.pin_out;
      assign pin_oe_w[g] = chif.pin_oe;
      tc2_wave_chan #(
        .TOGGLE_IN_PWM(g == 0)
      ) u_chan (
        .clk(clk_sys),
        .rst_n(rst_n),
        .ch(chif)
      );
    end
  endgenerate

  assign compare_out_a_pin = pin_out_w[0];
  assign compare_out_a_oe = pin_oe_w[0];
  assign compare_out_b_pin = pin_out_w[1];
  assign compare_out_b_oe = pin_oe_w[1];

  assign irq_set = {match_w[1], match_w[0], ovf_evt};
  assign irq_clr = wr_status ? wdata_q[2:0] : 3'h0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= tc2_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule

// ==== bench/tc2_timer_props.sv ====
// Bus handshake and pin property checker for the timer waveform block
`timescale 1ns/1ps
module tc2_timer_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_out_a_pin,
  input wire logic compare_out_a_oe,
  input wire logic compare_out_b_oe,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  rd_upper_a: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp != tc2_pkg::RESP_OKAY
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  aw_take_a: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready)
    else $error("write address ready stayed high");
  oe_write_a: assert property (
    $changed({compare_out_a_oe, compare_out_b_oe})
    |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin enable changed without a write");
  irq_fall_a: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  cover property (s_axi_bvalid && s_axi_bresp == tc2_pkg::RESP_SLVERR);
  cover property ($rose(irq));
  cover property ($rose(compare_out_a_pin));
endmodule

bind tc2_timer_top tc2_timer_props props_u (.*);

// ==== bench/tc2_timer_top_tb.sv ====
// Self-checking bench for the timer waveform block
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tc2_timer_top_tb;
  localparam logic [7:0] CA = tc2_pkg::ADDR_CTRL_A;
  localparam logic [7:0] CB = tc2_pkg::ADDR_CTRL_B;
  localparam logic [7:0] PC = tc2_pkg::ADDR_PIN_CFG;
  localparam logic [7:0] IS = tc2_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] IM = tc2_pkg::ADDR_IRQ_MASK;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic compare_out_a_pin, compare_out_a_oe, irq;
  logic compare_out_b_pin, compare_out_b_oe;
  int err_count = 0;
  int n_checks = 0;
  int ha, ta, hb, tb;
  tc2_timer_top #(.TICK_DIV(1)) dut_u (.*);
  always #4 clk_sys = ~clk_sys;

  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er = tc2_pkg::RESP_OKAY);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK({s_axi_bvalid, s_axi_bresp}, {1'b1, er})
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff,
                    input logic [1:0] er = tc2_pkg::RESP_OKAY);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK({s_axi_rvalid, s_axi_rresp, s_axi_rdata & {24'hff_ffff, m}},
      {1'b1, er, 24'h00_0000, e})
  endtask

  // Counts high cycles and changes of both pins over n clocks
  task automatic win(input int n);
    logic pa, pb;
    {ha, ta, hb, tb} = '0;
    pa = compare_out_a_pin;
    pb = compare_out_b_pin;
    repeat (n) begin
      @(posedge clk_sys);
      ha += int'(compare_out_a_pin);
      hb += int'(compare_out_b_pin);
      ta += int'(compare_out_a_pin != pa);
      tb += int'(compare_out_b_pin != pb);
      pa = compare_out_a_pin;
      pb = compare_out_b_pin;
    end
  endtask

  // Stops, configures from count zero, runs and lets the waveform settle
  task automatic go(input logic [7:0] ca, input logic [7:0] cb,
                    input logic [7:0] ma, input logic [7:0] mb);
    wr(CB, cb & 8'h08);
    wr(CA, ca);
    wr(tc2_pkg::ADDR_COUNTER, 8'h00);
    wr(tc2_pkg::ADDR_CMP_A, ma);
    wr(tc2_pkg::ADDR_CMP_B, mb);
    wr(IS, 8'h07);
    wr(CB, cb);
    repeat (1100) @(posedge clk_sys);
  endtask

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(CA + 8'(4 * i), 8'h00);
    wr(CA, 8'hff);
    rd(CA, 8'hf3);
    note("reset values");
    wr(PC, 8'h30);
    repeat (3) @(posedge clk_sys);
    `CHK({compare_out_a_oe, compare_out_b_oe}, 2'b00)
    wr(PC, 8'h33);
    wr(CA, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK({compare_out_a_oe, compare_out_b_oe}, 2'b11)
    `CHK({compare_out_a_pin, compare_out_b_pin}, 2'b11)
    wr(PC, 8'h03);
    repeat (3) @(posedge clk_sys);
    `CHK({compare_out_a_pin, compare_out_b_pin}, 2'b00)
    wr(PC, 8'h33);
    note("pin takeover");
    go(8'h50, 8'h01, 8'h05, 8'h07);
    win(1024);
    `CHK(ta + tb, 8)
    go(8'he0, 8'h01, 8'h05, 8'h07);
    win(300);
    `CHK(ha + 1000 * hb, 300)
    go(8'hb0, 8'h01, 8'h05, 8'h07);
    win(300);
    `CHK(ha + 1000 * hb, 300000)
    note("normal mode");
    go(8'h52, 8'h01, 8'h09, 8'h03);
    win(200);
    `CHK(ta * 100 + tb, 2020)
    rd(IS, 8'h06, 8'h07);
    note("clear on compare");
    go(8'hb3, 8'h01, 8'h3f, 8'h3f);
    win(1024);
    `CHK(ha > 247 && ha < 265, 1'b1)
    `CHK(ha + hb, 1024)
    rd(IS, 8'h01, 8'h01);
    // New compare B stays buffered, so the first climb still hits 0x3f
    wr(CB, 8'h00);
    wr(tc2_pkg::ADDR_CMP_B, 8'hf0);
    wr(tc2_pkg::ADDR_COUNTER, 8'h00);
    wr(IS, 8'h07);
    wr(CB, 8'h01);
    repeat (100) @(posedge clk_sys);
    wr(CB, 8'h00);
    rd(IS, 8'h04, 8'h04);
    go(8'h43, 8'h01, 8'h3f, 8'h3f);
    win(300);
    `CHK(ha + hb, 600)
    note("fast pwm fixed top");
    go(8'h63, 8'h09, 8'h14, 8'h0a);
    win(210);
    `CHK(ta, 10)
    `CHK(hb > 89 && hb < 121, 1'b1)
    rd(IS, 8'h01, 8'h01);
    go(8'ha3, 8'h09, 8'h14, 8'h14);
    win(210);
    `CHK(ha + hb, 420)
    go(8'he3, 8'h09, 8'h14, 8'h14);
    win(210);
    `CHK(ha, 0)
    note("fast pwm compare top");
    go(8'hb1, 8'h01, 8'h64, 8'h64);
    win(1020);
    `CHK(ha > 389 && ha < 411, 1'b1)
    `CHK(ha + hb, 1020)
    rd(IS, 8'h01, 8'h01);
    go(8'hb1, 8'h09, 8'h32, 8'h32);
    win(400);
    `CHK(ta + tb, 0)
    note("phase correct pwm");
    wr(CB, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(IM, 8'h01);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    rd(IM, 8'h01);
    wr(IS, 8'h07);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(IM, 8'h00);
    note("interrupt");
    rd(8'hd0, 8'h00, 8'hff, tc2_pkg::RESP_SLVERR);
    wr(8'hd0, 8'hff, tc2_pkg::RESP_SLVERR);
    // A write without lane 0 strobe answers but leaves the mask alone
    s_axi_wstrb <= 4'h0;
    wr(IM, 8'h07);
    s_axi_wstrb <= 4'h1;
    rd(IM, 8'h00);
    note("unmapped access");
    tally_and_finish;
  end
endmodule
